// [rtl/acc_pkg.sv]
// Package for the analog comparator control block: map, fields, types
package acc_pkg;
  // Register word indices; byte address is four times the index (haddr[9:2])
  localparam logic [7:0] ACC_IDX_CTRL_STATUS = 8'h50; // comparator_control_status index
  localparam logic [7:0] ACC_IDX_CONV_B = 8'h7B; // converter_control_b index
  localparam logic [7:0] ACC_IDX_DIDIS = 8'h7F; // digital_input_disable_one index
  localparam logic [7:0] ACC_IDX_AUX = 8'h80; // Extra read-only status index
  localparam logic [7:0] ACC_IDX_IRQ_STAT = 8'h81; // Sticky event status index
  localparam logic [7:0] ACC_IDX_IRQ_MASK = 8'h82; // Event mask index
  // Field positions in comparator_control_status
  localparam int ACC_BIT_DISABLE = 7;
  localparam int ACC_BIT_BANDGAP = 6;
  localparam int ACC_BIT_RESULT = 5;
  localparam int ACC_BIT_FLAG = 4;
  localparam int ACC_BIT_IRQ_EN = 3;
  localparam int ACC_BIT_CAPTURE = 2;
  localparam int ACC_BIT_MODE_HI = 1;
  localparam int ACC_BIT_MODE_LO = 0;
  // Field positions in converter_control_b
  localparam int ACC_BIT_MUX_NEG_EN = 6;
  localparam int ACC_BIT_MUX_HIGH = 3;
  // Field positions in digital_input_disable_one
  localparam int ACC_BIT_NEG_OFF = 1;
  localparam int ACC_BIT_POS_OFF = 0;
  // Write masks: reserved bits ignore writes
  localparam logic [7:0] ACC_WMASK_CS = 8'hDF;
  localparam logic [7:0] ACC_WMASK_CONV_B = 8'h4F;
  localparam logic [7:0] ACC_WMASK_DIDIS = 8'h03;
  // Reset values
  localparam logic [7:0] ACC_RESET_REG = 8'h00;
  localparam logic [1:0] ACC_RESET_EVT = 2'h0;
  // Event status bits: 0 edge event, 1 result change
  localparam int ACC_EVT_EDGE = 0;
  localparam int ACC_EVT_CHANGE = 1;
  // Interrupt mode encodings
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALL = 2'h2,
    ACC_MODE_RISE = 2'h3
  } acc_mode_type;
  // Analog front-end control bundle
  typedef struct packed {
    logic power_off;          // Comparator power switched off
    logic bandgap_sel;        // Positive input is bandgap
    logic neg_from_mux;       // Negative input from channel mux
    logic [3:0] neg_channel;  // Channel pin 0..15
    logic pos_pin_input_off;  // Digital buffer off, positive pin
    logic neg_pin_input_off;  // Digital buffer off, negative pin
  } acc_analog_ctl_type;
endpackage : acc_pkg

// [rtl/acc_ctrl.sv]
// Analog comparator control block with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog comparator raw output, asynchronous
  input wire logic comparator_raw,
  // Converter state from neighbouring registers
  input wire logic converter_enable,
  input wire logic converter_power_reduce,
  input wire logic [2:0] mux_select_low,
  // CPU interrupt context
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  // Raw digital pin levels, asynchronous
  input wire logic positive_input_pin,
  input wire logic negative_input_pin,
  // Analog front-end control
  output acc_analog_ctl_type analog_ctl,
  // Pin read values and timer capture source
  output logic positive_pin_read,
  output logic negative_pin_read,
  output logic capture_source,
  output logic capture_route_enable,
  // Interrupts
  output logic comparator_irq,
  output logic event_irq
);

  // Register storage
  logic [7:0] ctrl_status; // Writable bits; result and flag kept apart
  logic [7:0] conv_b; // converter_control_b
  logic [7:0] didis; // digital_input_disable_one
  logic comparator_irq_flag; // Sticky edge flag
  logic [1:0] evt_status; // Sticky event status
  logic [1:0] evt_mask; // Event mask

  // Synchronisers: stage one read only by stage two
  logic cmp_meta; // First stage, read only by the second
  logic cmp_sync; // Second stage, settled comparator level
  logic cmp_prev; // Last synchronised value, for edge detection
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;

  // Bus data-phase capture
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_index;

  // Address phase decode
  wire logic ap_valid = hsel && hready && htrans[1];
  wire logic [7:0] ap_index = haddr[9:2];

  // Byte address is four times the index
  wire logic [7:0] wdata8 = hwdata[7:0];

  // Views are plain wires so each register stays the single source
  // Field views of control bits
  wire logic comparator_disable = ctrl_status[ACC_BIT_DISABLE];
  wire logic bandgap_select = ctrl_status[ACC_BIT_BANDGAP];
  wire logic comparator_irq_enable = ctrl_status[ACC_BIT_IRQ_EN];
  wire acc_mode_type irq_mode = acc_mode_type'(ctrl_status[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO]);
  wire logic mux_negative_enable = conv_b[ACC_BIT_MUX_NEG_EN];
  wire logic mux_select_high = conv_b[ACC_BIT_MUX_HIGH];

  // Synchronised result; a powered-off comparator reads low
  // Gating after the synchroniser can show a fall; software masks the irq first
  wire logic comparator_result = cmp_sync && !comparator_disable;

  // Strobes fire in the data phase, one cycle after the address
  // Write strobes per register
  wire logic wr_cs = dp_write && (dp_index == ACC_IDX_CTRL_STATUS);
  wire logic wr_cb = dp_write && (dp_index == ACC_IDX_CONV_B);
  wire logic wr_dd = dp_write && (dp_index == ACC_IDX_DIDIS);
  wire logic wr_st = dp_write && (dp_index == ACC_IDX_IRQ_STAT);
  wire logic wr_mk = dp_write && (dp_index == ACC_IDX_IRQ_MASK);

  // Mux borrowed only with converter off and powered domain
  wire logic mux_borrowed = mux_negative_enable && !converter_enable
                            && !converter_power_reduce;

  // Edges are taken after gating, so a disable shows as a fall
  // Edge classification of synchronised result
  wire logic rise = comparator_result && !cmp_prev;
  wire logic fall = !comparator_result && cmp_prev;

  // Edge-to-mode match, reserved mode triggers nothing
  function automatic logic edge_hit(acc_mode_type m, logic r, logic f);
    case (m)
      ACC_MODE_TOGGLE: edge_hit = r | f;
      ACC_MODE_FALL: edge_hit = f;
      ACC_MODE_RISE: edge_hit = r;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  wire logic edge_event = edge_hit(irq_mode, rise, fall);

  // Flag clear by one-write or vector acknowledge; set wins
  wire logic flag_clear = (wr_cs && wdata8[ACC_BIT_FLAG]) || irq_vector_ack;
  wire logic next_flag = edge_event || (comparator_irq_flag && !flag_clear);

  // Bit 1 ignores the mode: any settled change of the result
  // Event sources for status register
  wire logic [1:0] evt_src = {rise | fall, edge_event};
  wire logic [1:0] next_evt = evt_src | (evt_status & ~(wr_st ? wdata8[1:0] : 2'h0));

  // Reads have no side effects; the flag clears only by write or vector
  // Read mux: reserved bits zero
  logic [7:0] rd_byte;
  always_comb begin
    case (dp_index)
      ACC_IDX_CTRL_STATUS: begin
        rd_byte = ctrl_status;
        rd_byte[ACC_BIT_RESULT] = comparator_result;
        rd_byte[ACC_BIT_FLAG] = comparator_irq_flag;
      end
      ACC_IDX_CONV_B: rd_byte = conv_b;
      ACC_IDX_DIDIS: rd_byte = didis;
      ACC_IDX_AUX: rd_byte = {7'h00, mux_borrowed};
      ACC_IDX_IRQ_STAT: rd_byte = {6'h00, evt_status};
      ACC_IDX_IRQ_MASK: rd_byte = {6'h00, evt_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // No wait states: every register answers in its data phase
  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = dp_read ? {24'h000000, rd_byte} : 32'h00000000;

  // Index is kept even when idle; the strobes carry the validity
  // Bus address-phase latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_index <= 8'h00;
    end else if (hready) begin
      dp_write <= ap_valid && hwrite;
      dp_read <= ap_valid && !hwrite;
      dp_index <= ap_index;
    end
  end

  // Bits 2:0 of converter_control_b are stored here too, though this block does not use them
  // Control registers, masked writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_status <= ACC_RESET_REG;
      conv_b <= ACC_RESET_REG;
      didis <= ACC_RESET_REG;
      evt_mask <= ACC_RESET_EVT;
    end else begin
      // Result and flag positions never stored here
      if (wr_cs) ctrl_status <= wdata8 & ACC_WMASK_CS & ~(8'h01 << ACC_BIT_FLAG);
      if (wr_cb) conv_b <= wdata8 & ACC_WMASK_CONV_B;
      if (wr_dd) didis <= wdata8 & ACC_WMASK_DIDIS;
      if (wr_mk) evt_mask <= wdata8[1:0];
    end
  end

  // Two stages bound metastability; a third flop keeps the edge history
  // Comparator and pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      cmp_prev <= 1'b0;
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      // Raw level enters untouched; gating waits for the second stage
      cmp_meta <= comparator_raw;
      cmp_sync <= cmp_meta;
      cmp_prev <= comparator_result;
      pin_meta <= {negative_input_pin, positive_input_pin};
      pin_sync <= pin_meta;
    end
  end

  // A clear in the same cycle as an edge loses, so no event is missed
  // Interrupt flag and event status; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comparator_irq_flag <= 1'b0;
      evt_status <= ACC_RESET_EVT;
    end else begin
      comparator_irq_flag <= next_flag;
      evt_status <= next_evt;
    end
  end

  // The analog side acts on these levels directly, with no delay
  // Analog control outputs
  assign analog_ctl.power_off = comparator_disable;
  assign analog_ctl.bandgap_sel = bandgap_select;
  assign analog_ctl.neg_from_mux = mux_borrowed;
  assign analog_ctl.neg_channel = mux_borrowed ? {mux_select_high, mux_select_low}
                                               : 4'h0;
  assign analog_ctl.pos_pin_input_off = didis[ACC_BIT_POS_OFF];
  assign analog_ctl.neg_pin_input_off = didis[ACC_BIT_NEG_OFF];

  // Synchronised first, then masked, as the port logic expects
  // Pin reads forced low while buffer disabled
  assign positive_pin_read = pin_sync[0] && !didis[ACC_BIT_POS_OFF];
  assign negative_pin_read = pin_sync[1] && !didis[ACC_BIT_NEG_OFF];

  // Limitation: the route carries the level only, no filtering here
  // Capture route: timer front end does its own filtering
  assign capture_route_enable = ctrl_status[ACC_BIT_CAPTURE];
  assign capture_source = capture_route_enable && comparator_result;

  // The event path sits beside the flag and has its own mask
  // Interrupt outputs
  assign comparator_irq = comparator_irq_flag && comparator_irq_enable
                          && global_irq_enable;
  assign event_irq = |(evt_status & evt_mask);

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sync_latency_a: assert property ($changed(cmp_sync) |->
    $past(cmp_meta) == cmp_sync) else $error("result not synchronised");
  flag_rise_a: assert property ((irq_mode == ACC_MODE_RISE) && rise |=>
    comparator_irq_flag) else $error("rise did not set flag");
  flag_fall_a: assert property ((irq_mode == ACC_MODE_FALL) && fall |=>
    comparator_irq_flag) else $error("fall did not set flag");
  reserved_mode_a: assert property ((irq_mode == ACC_MODE_RESERVED) && !comparator_irq_flag
    && !edge_event |=> !comparator_irq_flag) else $error("reserved mode set flag");
  flag_clear_a: assert property (irq_vector_ack && !edge_event |=>
    !comparator_irq_flag) else $error("flag not cleared");
  irq_gate_a: assert property (comparator_irq == (comparator_irq_flag
    && comparator_irq_enable && global_irq_enable)) else $error("irq gating wrong");
  neg_select_a: assert property ((converter_enable || !mux_negative_enable) |->
    !analog_ctl.neg_from_mux) else $error("mux used while not allowed");
  channel_sel_a: assert property (analog_ctl.neg_from_mux |->
    analog_ctl.neg_channel == {mux_select_high, mux_select_low}) else $error("bad channel");
  pin_off_a: assert property (didis[ACC_BIT_POS_OFF] |-> !positive_pin_read)
    else $error("disabled pin read high");
  disable_low_a: assert property (comparator_disable [*3] |-> !comparator_result)
    else $error("disabled comparator active");
  capture_off_a: assert property (!capture_route_enable |-> !capture_source)
    else $error("capture routed while off");

  // Flag hold and clear, routing, selection gating and reserved reads
  flag_toggle_a: assert property ((irq_mode == ACC_MODE_TOGGLE) && (rise || fall) |=>
    comparator_irq_flag) else $error("toggle did not set flag");
  flag_hold_a: assert property (comparator_irq_flag && !flag_clear |=>
    comparator_irq_flag) else $error("flag lost without clear");
  flag_w1c_a: assert property (wr_cs && wdata8[ACC_BIT_FLAG] && !edge_event |=>
    !comparator_irq_flag) else $error("write one did not clear flag");
  neg_pin_off_a: assert property (didis[ACC_BIT_NEG_OFF] |-> !negative_pin_read)
    else $error("disabled negative pin read high");
  capture_on_a: assert property (capture_route_enable |->
    capture_source == comparator_result) else $error("capture not following result");
  mux_gate_a: assert property (converter_power_reduce |->
    !analog_ctl.neg_from_mux) else $error("mux used under power reduction");
  reserved_read_a: assert property (dp_read && (dp_index == ACC_IDX_CONV_B) |->
    ((hrdata[7:0] & ~ACC_WMASK_CONV_B) == 8'h00) && (hrdata[31:8] == 24'h000000))
    else $error("reserved bits read nonzero");

  // Scenarios worth seeing in a run
  flag_set_c: cover property (rise ##1 comparator_irq_flag);
  irq_fire_c: cover property (comparator_irq ##1 irq_vector_ack);
  mux_used_c: cover property (analog_ctl.neg_from_mux);
  capture_c: cover property (capture_source);
  disable_fall_c: cover property (comparator_disable && fall);

endmodule : acc_ctrl
`default_nettype wire

// [test/acc_partner.sv]
// Behavioural analog front end: comparator decision from pin and channel levels
`timescale 1ns/1ps
`default_nettype none
module acc_partner
  import acc_pkg::*;
#(
  parameter logic [7:0] BANDGAP_LEVEL = 8'h80 // Plain default reference level
) (
  // Front-end control from the block
  input wire acc_analog_ctl_type analog_ctl,
  // Levels on pins and channels
  input wire logic [7:0] pos_level,
  input wire logic [7:0] neg_level,
  input wire logic [15:0][7:0] chan_level,
  // Raw decision, asynchronous
  output logic comparator_raw
);
  // Positive side: bandgap or pin
  wire logic [7:0] plus_in = analog_ctl.bandgap_sel ? BANDGAP_LEVEL : pos_level;
  // Negative side: channel only when the block borrows the mux
  wire logic [7:0] minus_in = analog_ctl.neg_from_mux ?
    chan_level[analog_ctl.neg_channel] : neg_level;
  // Powered-off comparator never reports positive above negative
  assign comparator_raw = !analog_ctl.power_off && (plus_in > minus_in);
endmodule : acc_partner
`default_nettype wire

// [test/acc_ctrl_test.sv]
// Register-level testbench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_test
  import acc_pkg::*;
;
  localparam logic [31:0] A_CS = {22'h0, ACC_IDX_CTRL_STATUS, 2'h0};
  localparam logic [31:0] A_CB = {22'h0, ACC_IDX_CONV_B, 2'h0};
  localparam logic [31:0] A_DD = {22'h0, ACC_IDX_DIDIS, 2'h0};
  localparam logic [31:0] A_AUX = {22'h0, ACC_IDX_AUX, 2'h0};
  localparam logic [31:0] A_ST = {22'h0, ACC_IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] A_MK = {22'h0, ACC_IDX_IRQ_MASK, 2'h0};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, comparator_raw;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic converter_enable, converter_power_reduce, global_irq_enable, irq_vector_ack;
  logic [2:0] mux_select_low;
  logic positive_input_pin, negative_input_pin, positive_pin_read, negative_pin_read;
  logic capture_source, capture_route_enable, comparator_irq, event_irq;
  acc_analog_ctl_type analog_ctl;
  logic [7:0] pos_level, neg_level;
  logic [15:0][7:0] chan_level;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] q;
  acc_ctrl i_acc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comparator_raw(comparator_raw),
    .converter_enable(converter_enable), .converter_power_reduce(converter_power_reduce),
    .mux_select_low(mux_select_low), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .positive_input_pin(positive_input_pin),
    .negative_input_pin(negative_input_pin), .analog_ctl(analog_ctl),
    .positive_pin_read(positive_pin_read), .negative_pin_read(negative_pin_read),
    .capture_source(capture_source), .capture_route_enable(capture_route_enable),
    .comparator_irq(comparator_irq), .event_irq(event_irq));
  acc_partner i_acc_partner (.analog_ctl(analog_ctl), .pos_level(pos_level),
    .neg_level(neg_level), .chan_level(chan_level), .comparator_raw(comparator_raw));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Compare and count
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // One single transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata; // Pre-edge value: flops update later in the step
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input string n, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(n, q, exp);
  endtask : rc
  // Verdict in one place
  task automatic test_done;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Hang guard, far above the roughly 350 cycles needed
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, irq_vector_ack} = '0;
    {converter_enable, converter_power_reduce, mux_select_low, global_irq_enable} = '0;
    hsize = 3'h2;
    positive_input_pin = 1'b1;
    negative_input_pin = 1'b1;
    pos_level = 8'h0A;
    neg_level = 8'h14;
    for (int i = 0; i < 16; i++) chan_level[i] = 8'(i * 10);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc("cs reset", A_CS, 32'h0);
    rc("cb reset", A_CB, 32'h0);
    rc("dd reset", A_DD, 32'h0);
    wr(A_CB, 32'hFF);
    rc("cb reserved", A_CB, 32'h4F);
    wr(A_DD, 32'hFF);
    rc("dd reserved", A_DD, 32'h03);
    check("pins off", {positive_pin_read, negative_pin_read}, 32'h0);
    check("buf off", analog_ctl[1:0], 32'h3);
    wr(A_DD, 32'h0);
    repeat (3) @(posedge hclk);
    check("pins on", {positive_pin_read, negative_pin_read}, 32'h3);
    negative_input_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    check("pin low", {positive_pin_read, negative_pin_read}, 32'h2);
    rc("unmapped", 32'h3FC, 32'h0);
    check("okay", {hreadyout, hresp}, 32'h2);
    $display("test registers done");
    // Every channel, reserved mode so no flag
    wr(A_CS, 32'h11);
    pos_level <= 8'h4B;
    for (int i = 0; i < 16; i++) begin
      mux_select_low <= 3'(i);
      wr(A_CB, 32'h40 | (32'(i / 8) << 3));
      repeat (3) @(posedge hclk);
      check("channel", {analog_ctl.neg_from_mux, analog_ctl.neg_channel}, 5'h10 | i);
      rc("mux result", A_CS, (75 > i * 10) ? 32'h21 : 32'h01);
    end
    converter_enable <= 1'b1;
    rc("conv on", A_AUX, 32'h0);
    check("neg pin", analog_ctl.neg_from_mux, 32'h0);
    converter_enable <= 1'b0;
    converter_power_reduce <= 1'b1;
    rc("power reduce", A_AUX, 32'h0);
    converter_power_reduce <= 1'b0;
    wr(A_CB, 32'h0);
    pos_level <= 8'h05;
    $display("test mux done");
    // Bandgap above pin level, then power off
    wr(A_CS, 32'h50);
    repeat (4) @(posedge hclk);
    rc("bandgap", A_CS, 32'h70);
    check("bandgap sel", analog_ctl.bandgap_sel, 32'h1);
    wr(A_CS, 32'hD0);
    repeat (4) @(posedge hclk);
    check("power off", analog_ctl.power_off, 32'h1);
    rc("disabled", A_CS, 32'hD0);
    wr(A_CS, 32'h10);
    rc("on again", A_CS, 32'h0);
    $display("test bandgap done");
    // Each mode against a rise and a fall
    for (int m = 0; m < 4; m++) begin
      wr(A_CS, 32'h10 | m);
      pos_level <= 8'h4B;
      repeat (4) @(posedge hclk);
      rc("rise", A_CS, 32'h20 | m | ((m == 0 || m == 3) ? 32'h10 : 32'h0));
      wr(A_CS, 32'h10 | m);
      pos_level <= 8'h05;
      repeat (4) @(posedge hclk);
      rc("fall", A_CS, m | ((m == 0 || m == 2) ? 32'h10 : 32'h0));
    end
    $display("test modes done");
    // Request gating and clearing
    pos_level <= 8'h4B;
    repeat (4) @(posedge hclk);
    check("irq off", comparator_irq, 32'h0);
    wr(A_CS, 32'h0B);
    @(posedge hclk);
    check("no global", comparator_irq, 32'h0);
    global_irq_enable <= 1'b1;
    @(posedge hclk);
    check("irq on", comparator_irq, 32'h1);
    rc("write zero", A_CS, 32'h3B);
    irq_vector_ack <= 1'b1;
    @(posedge hclk);
    irq_vector_ack <= 1'b0;
    @(posedge hclk);
    check("vector", comparator_irq, 32'h0);
    rc("vector clr", A_CS, 32'h2B);
    global_irq_enable <= 1'b0;
    // Capture routing
    wr(A_CS, 32'h0);
    check("no route", capture_source, 32'h0);
    wr(A_CS, 32'h04);
    @(posedge hclk);
    check("route", {capture_route_enable, capture_source}, 32'h3);
    pos_level <= 8'h05;
    repeat (4) @(posedge hclk);
    check("route low", capture_source, 32'h0);
    // Event status and mask
    wr(A_ST, 32'h3);
    wr(A_MK, 32'h1);
    check("ev idle", event_irq, 32'h0);
    pos_level <= 8'h4B;
    repeat (4) @(posedge hclk);
    check("ev set", event_irq, 32'h1);
    rc("ev status", A_ST, 32'h3);
    wr(A_MK, 32'h0);
    @(posedge hclk);
    check("ev masked", event_irq, 32'h0);
    wr(A_ST, 32'h3);
    rc("ev clear", A_ST, 32'h0);
    $display("test events done");
    test_done();
  end
endmodule : acc_ctrl_test
`default_nettype wire
